// File: hw/low_frequency_clock_ctrl.sv
// Low-frequency clock source, crystal start and trace configuration
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
module lf_clock_ctrl
	import lf_clock_pkg::*;
#(
	parameter int HF_POWER_UP = HF_POWER_UP_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        DEBUG_RESET_N,
	input  wire logic        POWER_ON_RESET_N,
	input  wire logic [11:0] AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             AVS_RESPONSE_ERR,
	input  wire logic        LF_OSC_READY,
	output logic             LF_OSC_ENABLE,
	output logic [1:0]       LF_SOURCE,
	output logic             LF_BYPASS,
	output logic             LF_EXTERNAL,
	output logic             HF_XTAL_ENABLE,
	output logic             HF_STARTED,
	output logic             IRQ,
	output logic             TRACE_CLOCK_PIN,
	output logic             TRACE_CLOCK_ROUTED,
	output logic             TRACE_DATA_ROUTED,
	output logic             SERIAL_TRACE_ROUTED
);
	initial begin
		if (HF_POWER_UP < 1) $error("power-up count must be positive");
	end

	logic        rst_s1_q;
	logic        rst_n;
	logic        ack_q;
	logic        wr;
	logic        rd;
	logic [31:0] wmask;
	logic [31:0] lf_select_q;
	logic [1:0]  lf_shadow_q;
	logic [1:0]  lf_active_q;
	logic        lf_running_q;
	logic        lf_starting_q;
	logic [6:0]  lf_cnt_q;
	logic [31:0] debounce_q;
	logic [31:0] rc_mode_q;
	logic [31:0] cal_interval;
	logic [31:0] trace_cfg;
	hf_state_t   hf_state_q;
	logic [31:0] hf_cnt_q;
	logic        hf_event;
	logic        lf_event;
	logic [1:0]  irq_status_q;
	logic [1:0]  irq_mask_q;
	logic        hf_task;
	logic        lf_task;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a[11:2] == o[11:2]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// Reset release through two flops
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// One wait state per access
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
		end
	end

	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign wr = AVS_WRITE & ack_q;
	assign rd = AVS_READ & ~ack_q;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi*8 +: 8] = {8{AVS_BYTEENABLE[gi]}};
		end
	endgenerate

	assign hf_task = wr & hit(AVS_ADDRESS, OFS_TASK_HF_START)
		& AVS_WRITEDATA[0] & AVS_BYTEENABLE[0];
	assign lf_task = wr & hit(AVS_ADDRESS, OFS_TASK_LF_START)
		& AVS_WRITEDATA[0] & AVS_BYTEENABLE[0];

	// Source selection: source, bypass and external bits
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			lf_select_q <= RST_LF_SELECT;
		end else if (wr && hit(AVS_ADDRESS, OFS_LF_SELECT)) begin
			lf_select_q <= merge(lf_select_q, AVS_WRITEDATA, wmask)
				& 32'h0003_0003;
		end
	end

	assign LF_SOURCE   = lf_select_q[SOURCE_LSB +: 2];
	assign LF_BYPASS   = lf_select_q[BYPASS_BIT];
	assign LF_EXTERNAL = lf_select_q[EXTERNAL_BIT];

	// Shadow copy taken on start task
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			lf_shadow_q <= RST_LF_SHADOW[1:0];
		end else if (lf_task) begin
			lf_shadow_q <= lf_select_q[SOURCE_LSB +: 2];
		end
	end

	// Low-frequency start: running after oscillator ready and settle count
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			lf_starting_q <= 1'b0;
			lf_running_q  <= 1'b0;
			lf_active_q   <= SOURCE_RC;
			lf_cnt_q      <= 7'd0;
		end else if (lf_task) begin
			lf_starting_q <= 1'b1;
			lf_running_q  <= 1'b0;
			lf_active_q   <= lf_select_q[SOURCE_LSB +: 2];
			lf_cnt_q      <= 7'd0;
		end else if (lf_starting_q && LF_OSC_READY) begin
			if (lf_cnt_q == 7'(LF_START_CYC - 1)) begin
				lf_starting_q <= 1'b0;
				lf_running_q  <= 1'b1;
			end else begin
				lf_cnt_q <= lf_cnt_q + 7'd1;
			end
		end
	end

	assign lf_event = lf_starting_q & LF_OSC_READY
		& (lf_cnt_q == 7'(LF_START_CYC - 1));
	assign LF_OSC_ENABLE = lf_starting_q | lf_running_q;

	// Debounce register; writes during start-up are software's to avoid
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			debounce_q <= RST_HF_DEBOUNCE;
		end else if (wr && hit(AVS_ADDRESS, OFS_HF_DEBOUNCE)) begin
			debounce_q <= merge(debounce_q, AVS_WRITEDATA, wmask);
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rc_mode_q <= RST_LF_RC_MODE;
		end else if (wr && hit(AVS_ADDRESS, OFS_LF_RC_MODE)) begin
			rc_mode_q <= merge(rc_mode_q, AVS_WRITEDATA, wmask) & 32'h0000_0003;
		end
	end

	// Crystal start sequence: power-up then debounce
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			hf_state_q <= HF_OFF;
			hf_cnt_q   <= 32'h0000_0000;
		end else begin
			case (hf_state_q)
				HF_OFF: begin
					if (hf_task) begin
						hf_state_q <= HF_POWERUP;
						hf_cnt_q   <= 32'(HF_POWER_UP - 1);
					end
				end
				HF_POWERUP: begin
					if (hf_cnt_q == 32'h0000_0000) begin
						hf_state_q <= HF_DEBOUNCE;
						hf_cnt_q   <= 32'(debounce_q[7:0] * DEBOUNCE_UNIT_CYC);
					end else begin
						hf_cnt_q <= hf_cnt_q - 32'h0000_0001;
					end
				end
				HF_DEBOUNCE: begin
					if (hf_cnt_q == 32'h0000_0000) begin
						hf_state_q <= HF_RUN;
					end else begin
						hf_cnt_q <= hf_cnt_q - 32'h0000_0001;
					end
				end
				HF_RUN: begin
					hf_state_q <= HF_RUN;
				end
				default: hf_state_q <= HF_OFF;
			endcase
		end
	end

	assign hf_event = (hf_state_q == HF_DEBOUNCE) && (hf_cnt_q == 32'h0);
	assign HF_XTAL_ENABLE = (hf_state_q != HF_OFF);
	assign HF_STARTED = (hf_state_q == HF_RUN);

	// Sticky status, set wins over write-one-to-clear
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_q <= 2'h0;
		end else begin
			if (wr && hit(AVS_ADDRESS, OFS_IRQ_STATUS) && AVS_BYTEENABLE[0]) begin
				irq_status_q <= irq_status_q & ~AVS_WRITEDATA[1:0]
					| {lf_event, hf_event};
			end else begin
				irq_status_q <= irq_status_q | {lf_event, hf_event};
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_q <= 2'h0;
		end else if (wr && hit(AVS_ADDRESS, OFS_IRQ_MASK) && AVS_BYTEENABLE[0]) begin
			irq_mask_q <= AVS_WRITEDATA[1:0];
		end
	end

	assign IRQ = |(irq_status_q & irq_mask_q);

	// Calibration interval survives system reset
	lf_clock_retained_reg #(.WIDTH(32), .INIT(RST_CAL_INTERVAL)) u_cal (
		.clk        (CLK),
		.keep_rst_n (POWER_ON_RESET_N),
		.wr         (wr && hit(AVS_ADDRESS, OFS_CAL_INTERVAL)),
		.wdata      (merge(cal_interval, AVS_WRITEDATA, wmask) & 32'h0000_007f),
		.value      (cal_interval)
	);

	// Trace configuration cleared by debug reset only
	lf_clock_retained_reg #(.WIDTH(32), .INIT(RST_TRACE_CONFIG)) u_trace (
		.clk        (CLK),
		.keep_rst_n (DEBUG_RESET_N),
		.wr         (wr && hit(AVS_ADDRESS, OFS_TRACE_CONFIG)),
		.wdata      (merge(trace_cfg, AVS_WRITEDATA, wmask) & 32'h0003_0003),
		.value      (trace_cfg)
	);

	lf_clock_trace_clock u_tclk (
		.clk          (CLK),
		.rst_n        (DEBUG_RESET_N),
		.speed        (trace_cfg[SPEED_LSB +: 2]),
		.routing      (trace_cfg[ROUTING_LSB +: 2]),
		.trace_clk    (TRACE_CLOCK_PIN),
		.clk_route    (TRACE_CLOCK_ROUTED),
		.data_route   (TRACE_DATA_ROUTED),
		.serial_route (SERIAL_TRACE_ROUTED)
	);

	// Read data registered on the first cycle, presented with waitrequest low
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			AVS_READDATA     <= 32'h0000_0000;
			AVS_RESPONSE_ERR <= 1'b0;
		end else if (rd) begin
			AVS_RESPONSE_ERR <= 1'b0;
			case (1'b1)
				hit(AVS_ADDRESS, OFS_LF_STATUS): AVS_READDATA <=
					{15'h0, lf_running_q, 14'h0, lf_active_q};
				hit(AVS_ADDRESS, OFS_LF_SHADOW): AVS_READDATA <=
					{30'h0, lf_shadow_q};
				hit(AVS_ADDRESS, OFS_LF_SELECT):    AVS_READDATA <= lf_select_q;
				hit(AVS_ADDRESS, OFS_HF_DEBOUNCE):  AVS_READDATA <= debounce_q;
				hit(AVS_ADDRESS, OFS_CAL_INTERVAL): AVS_READDATA <= cal_interval;
				hit(AVS_ADDRESS, OFS_TRACE_CONFIG): AVS_READDATA <= trace_cfg;
				hit(AVS_ADDRESS, OFS_LF_RC_MODE):   AVS_READDATA <= rc_mode_q;
				hit(AVS_ADDRESS, OFS_IRQ_STATUS):
					AVS_READDATA <= {30'h0, irq_status_q};
				hit(AVS_ADDRESS, OFS_IRQ_MASK):
					AVS_READDATA <= {30'h0, irq_mask_q};
				hit(AVS_ADDRESS, OFS_TASK_HF_START),
				hit(AVS_ADDRESS, OFS_TASK_LF_START):
					AVS_READDATA <= 32'h0000_0000;
				default: begin
					AVS_READDATA     <= 32'h0000_0000;
					AVS_RESPONSE_ERR <= 1'b1;
				end
			endcase
		end
	end

	a_shadow_copy: assert property (
		@(posedge CLK) disable iff (!rst_n)
		lf_task |=> lf_shadow_q == $past(lf_select_q[1:0]))
		else $error("shadow not copied on start");
	a_shadow_hold: assert property (
		@(posedge CLK) disable iff (!rst_n)
		!lf_task |=> $stable(lf_shadow_q))
		else $error("shadow changed without start");
	a_hf_enable: assert property (
		@(posedge CLK) disable iff (!rst_n)
		hf_task && hf_state_q == HF_OFF |=> HF_XTAL_ENABLE)
		else $error("crystal not enabled by task");
	a_hf_no_early: assert property (
		@(posedge CLK) disable iff (!rst_n)
		$rose(hf_state_q == HF_POWERUP) |-> !HF_STARTED [*2])
		else $error("started too early");
	a_hf_event_run: assert property (
		@(posedge CLK) disable iff (!rst_n)
		hf_event |=> HF_STARTED && irq_status_q[IRQ_HF_BIT])
		else $error("event without run or status");
	a_hf_status_clr: assert property (
		@(posedge CLK) disable iff (!rst_n)
		wr && hit(AVS_ADDRESS, OFS_IRQ_STATUS) && AVS_BYTEENABLE[0]
			&& AVS_WRITEDATA[IRQ_HF_BIT] && !hf_event
		|=> !irq_status_q[IRQ_HF_BIT])
		else $error("started status not cleared");
	a_lf_running: assert property (
		@(posedge CLK) disable iff (!rst_n)
		lf_event |=> lf_running_q && lf_active_q == $past(lf_active_q))
		else $error("running bit not set");
	a_lf_restart: assert property (
		@(posedge CLK) disable iff (!rst_n)
		lf_task |=> lf_starting_q && !lf_running_q)
		else $error("start task did not restart clock");
	a_src_legal: assert property (
		@(posedge CLK) disable iff (!rst_n)
		lf_select_q[31:18] == 14'h0 && lf_select_q[15:2] == 14'h0)
		else $error("reserved select bits set");
	a_cal_write: assert property (
		@(posedge CLK) disable iff (!rst_n)
		wr && hit(AVS_ADDRESS, OFS_CAL_INTERVAL) && AVS_BYTEENABLE == 4'hf
		|=> cal_interval == ($past(AVS_WRITEDATA) & 32'h0000_007f))
		else $error("interval write lost");
	a_trace_fields: assert property (
		@(posedge CLK) disable iff (!DEBUG_RESET_N)
		trace_cfg[31:18] == 14'h0 && trace_cfg[15:2] == 14'h0)
		else $error("reserved trace bits set");
	a_route_excl: assert property (
		@(posedge CLK) disable iff (!DEBUG_RESET_N)
		!(SERIAL_TRACE_ROUTED && TRACE_DATA_ROUTED))
		else $error("serial and parallel both routed");
	a_trace_serial: assert property (
		@(posedge CLK) disable iff (!DEBUG_RESET_N)
		trace_cfg[ROUTING_LSB +: 2] == ROUTE_SERIAL
		|=> SERIAL_TRACE_ROUTED && !TRACE_CLOCK_ROUTED && !TRACE_DATA_ROUTED)
		else $error("serial routing wrong");
	a_ext_flags: assert property (
		@(posedge CLK) disable iff (!rst_n)
		wr && hit(AVS_ADDRESS, OFS_LF_SELECT) && AVS_BYTEENABLE[2]
		|=> LF_EXTERNAL == $past(AVS_WRITEDATA[EXTERNAL_BIT])
			&& LF_BYPASS == $past(AVS_WRITEDATA[BYPASS_BIT]))
		else $error("external flags mismatch");

	c_hf_start: cover property (@(posedge CLK) disable iff (!rst_n) hf_event);
	c_lf_start: cover property (@(posedge CLK) disable iff (!rst_n) lf_event);
	c_irq:      cover property (@(posedge CLK) disable iff (!rst_n) IRQ);
	c_parallel: cover property (@(posedge CLK) TRACE_DATA_ROUTED);
endmodule

// File: hw/low_frequency_clock_pkg.sv
// Constants for the low-frequency clock source and trace configuration block
// Notes on behaviour
// - Status reports active source and running bit
// - Start task copies source selection to shadow
// - Source field: 0 RC, 1 crystal, 2 synth
// - Bypass bit selects rail-to-rail external clock
// - External bit takes external source instead of crystal
// - High-frequency start task starts the crystal
// - Started event after power-up plus debounce time
// - Calibration interval kept across ordinary resets
// - Trace speed field: 16, 8, 4, 2 MHz
// - Trace config reset only by debug reset
package lf_clock_pkg;
	localparam logic [11:0] OFS_TASK_HF_START   = 12'h000;
	localparam logic [11:0] OFS_TASK_LF_START   = 12'h008;
	localparam logic [11:0] OFS_IRQ_STATUS      = 12'h100;
	localparam logic [11:0] OFS_IRQ_MASK        = 12'h304;
	localparam logic [11:0] OFS_LF_STATUS       = 12'h418;
	localparam logic [11:0] OFS_LF_SHADOW       = 12'h41c;
	localparam logic [11:0] OFS_LF_SELECT       = 12'h518;
	localparam logic [11:0] OFS_HF_DEBOUNCE     = 12'h528;
	localparam logic [11:0] OFS_CAL_INTERVAL    = 12'h538;
	localparam logic [11:0] OFS_TRACE_CONFIG    = 12'h55c;
	localparam logic [11:0] OFS_LF_RC_MODE      = 12'h5b4;

	localparam int SOURCE_LSB   = 0;
	localparam int BYPASS_BIT   = 16;
	localparam int EXTERNAL_BIT = 17;
	localparam int RUNNING_BIT  = 16;
	localparam int SPEED_LSB    = 0;
	localparam int ROUTING_LSB  = 16;
	localparam int IRQ_HF_BIT   = 0;
	localparam int IRQ_LF_BIT   = 1;

	localparam logic [1:0] SOURCE_RC    = 2'h0;
	localparam logic [1:0] SOURCE_XTAL  = 2'h1;
	localparam logic [1:0] SOURCE_SYNTH = 2'h2;

	localparam logic [1:0] ROUTE_GPIO     = 2'h0;
	localparam logic [1:0] ROUTE_SERIAL   = 2'h1;
	localparam logic [1:0] ROUTE_PARALLEL = 2'h2;

	localparam logic [31:0] RST_LF_SELECT    = 32'h0000_0000;
	localparam logic [31:0] RST_LF_SHADOW    = 32'h0000_0000;
	localparam logic [31:0] RST_TRACE_CONFIG = 32'h0000_0000;
	localparam logic [31:0] RST_HF_DEBOUNCE  = 32'h0000_0010;
	localparam logic [31:0] RST_CAL_INTERVAL = 32'h0000_0000;
	localparam logic [31:0] RST_LF_RC_MODE   = 32'h0000_0000;

	localparam int CLK_MHZ          = 250;
	localparam int HF_POWER_UP_US   = 50;
	localparam int HF_POWER_UP_CYC  = HF_POWER_UP_US * CLK_MHZ;
	localparam int DEBOUNCE_UNIT_NS = 16;
	localparam int DEBOUNCE_UNIT_CYC = (DEBOUNCE_UNIT_NS * CLK_MHZ + 999) / 1000;
	localparam int LF_START_CYC     = 64;

	typedef enum logic [1:0] {HF_OFF, HF_POWERUP, HF_DEBOUNCE, HF_RUN} hf_state_t;
endpackage

// File: hw/low_frequency_clock_retained_reg.sv
// Register that ignores system reset and clears only on its own reset
`timescale 1ns/10ps
module lf_clock_retained_reg
	import lf_clock_pkg::*;
#(
	parameter int          WIDTH = 32,
	parameter logic [31:0] INIT  = 32'h0000_0000
) (
	input  wire logic             clk,
	input  wire logic             keep_rst_n,
	input  wire logic             wr,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] value
);
	initial begin
		if (WIDTH < 1 || WIDTH > 32) $error("bad width");
	end

	always_ff @(posedge clk or negedge keep_rst_n) begin
		if (!keep_rst_n) begin
			value <= INIT[WIDTH-1:0];
		end else if (wr) begin
			value <= wdata;
		end
	end
endmodule

// File: hw/low_frequency_clock_trace_clock.sv
// Trace clock divider and trace pin routing
`timescale 1ns/10ps
module lf_clock_trace_clock
	import lf_clock_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] speed,
	input  wire logic [1:0] routing,
	output logic            trace_clk,
	output logic            clk_route,
	output logic            data_route,
	output logic            serial_route
);
	logic [5:0] div_q;
	logic [5:0] limit;

	// Half period minus one in system cycles for 16/8/4/2 MHz at 250 MHz, rounded
	always_comb begin
		case (speed)
			2'h0: limit = 6'd7;
			2'h1: limit = 6'd15;
			2'h2: limit = 6'd30;
			default: limit = 6'd61;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 6'd0;
		end else if (div_q >= limit) begin
			div_q <= 6'd0;
		end else begin
			div_q <= div_q + 6'd1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trace_clk <= 1'b0;
		end else if (div_q >= limit) begin
			trace_clk <= ~trace_clk;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_route    <= 1'b0;
			data_route   <= 1'b0;
			serial_route <= 1'b0;
		end else begin
			clk_route    <= (routing == ROUTE_PARALLEL);
			data_route   <= (routing == ROUTE_PARALLEL);
			serial_route <= (routing == ROUTE_SERIAL);
		end
	end
endmodule

// File: bench/low_frequency_clock_ctrl_tb.sv
// Register-level testbench for the clock source and trace config block
`timescale 1ns/10ps
module lf_clock_source_and_trace_config_tb_top;
	import lf_clock_pkg::*;
	localparam int PU = 10;
	logic        CLK, RESET_N, DEBUG_RESET_N, POWER_ON_RESET_N;
	logic [11:0] AVS_ADDRESS;
	logic        AVS_READ, AVS_WRITE, AVS_WAITREQUEST, AVS_RESPONSE_ERR;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA;
	logic [3:0]  AVS_BYTEENABLE;
	logic        LF_OSC_READY, LF_OSC_ENABLE, LF_BYPASS, LF_EXTERNAL;
	logic [1:0]  LF_SOURCE;
	logic        HF_XTAL_ENABLE, HF_STARTED, IRQ, TRACE_CLOCK_PIN;
	logic        TRACE_CLOCK_ROUTED, TRACE_DATA_ROUTED, SERIAL_TRACE_ROUTED;
	int          fails, tests_run;
	logic [31:0] q;
	logic        e;
	int          n;
	lf_clock_ctrl #(.HF_POWER_UP(PU)) DUT (.CLK(CLK), .RESET_N(RESET_N),
		.DEBUG_RESET_N(DEBUG_RESET_N), .POWER_ON_RESET_N(POWER_ON_RESET_N),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST),
		.AVS_RESPONSE_ERR(AVS_RESPONSE_ERR), .LF_OSC_READY(LF_OSC_READY),
		.LF_OSC_ENABLE(LF_OSC_ENABLE), .LF_SOURCE(LF_SOURCE),
		.LF_BYPASS(LF_BYPASS), .LF_EXTERNAL(LF_EXTERNAL),
		.HF_XTAL_ENABLE(HF_XTAL_ENABLE), .HF_STARTED(HF_STARTED), .IRQ(IRQ),
		.TRACE_CLOCK_PIN(TRACE_CLOCK_PIN),
		.TRACE_CLOCK_ROUTED(TRACE_CLOCK_ROUTED),
		.TRACE_DATA_ROUTED(TRACE_DATA_ROUTED),
		.SERIAL_TRACE_ROUTED(SERIAL_TRACE_ROUTED));
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	task report_and_stop;
		$display("Comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// One bus access, entered just after a rising edge, leaves one idle cycle
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= w;
		AVS_READ <= ~w;
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
		q = AVS_READDATA;
		e = AVS_RESPONSE_ERR;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		acc(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task rst_sys;
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (3) @(posedge CLK);
	endtask
	// Half period of the trace clock pin, in system clock cycles
	task half(output int h);
		logic v;
		int   k;
		@(negedge CLK);
		v = TRACE_CLOCK_PIN;
		k = 0;
		while (TRACE_CLOCK_PIN === v && k < 300) begin
			@(negedge CLK);
			k++;
		end
		v = TRACE_CLOCK_PIN;
		h = 0;
		while (TRACE_CLOCK_PIN === v && h < 300) begin
			@(negedge CLK);
			h++;
		end
	endtask
	initial begin
		#100000;
		fails++;
		report_and_stop;
	end
	initial begin
		int x;
		fails = 0;
		tests_run = 0;
		{RESET_N, DEBUG_RESET_N, POWER_ON_RESET_N} = 3'h0;
		{AVS_READ, AVS_WRITE, LF_OSC_READY} = 3'h0;
		AVS_ADDRESS = 12'h000;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hf;
		repeat (2) @(posedge CLK);
		{RESET_N, DEBUG_RESET_N, POWER_ON_RESET_N} <= 3'h7;
		repeat (3) @(posedge CLK);
		rd(OFS_LF_SELECT, 32'h0);
		rd(OFS_LF_SHADOW, 32'h0);
		rd(OFS_TRACE_CONFIG, 32'h0);
		rd(OFS_LF_STATUS, 32'h0);
		rd(OFS_HF_DEBOUNCE, 32'h10);
		rd(12'h7f0, 32'h0);
		chk({31'h0, e}, 32'h1);
		for (int s = 0; s < 3; s++) begin
			x = s | ((s == 1) ? 32'h3_0000 : 32'h0);
			wr(OFS_LF_SELECT, x);
			rd(OFS_LF_SELECT, x);
			chk({LF_EXTERNAL, LF_BYPASS, LF_SOURCE}, x[17:16] << 2 | s);
		end
		wr(OFS_LF_SHADOW, 32'hffff_ffff);
		rd(OFS_LF_SHADOW, 32'h0);
		wr(OFS_TASK_LF_START, 32'h1);
		rd(OFS_LF_SHADOW, 32'h2);
		wr(OFS_LF_SELECT, 32'h1);
		rd(OFS_LF_SHADOW, 32'h2);
		chk({31'h0, LF_OSC_ENABLE}, 32'h1);
		LF_OSC_READY <= 1'b1;
		repeat (70) @(posedge CLK);
		rd(OFS_LF_STATUS, 32'h0001_0002);
		rd(OFS_IRQ_STATUS, 32'h2);
		chk({31'h0, IRQ}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h2);
		chk({31'h0, IRQ}, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h2);
		chk({31'h0, IRQ}, 32'h0);
		rd(OFS_IRQ_STATUS, 32'h0);
		wr(OFS_HF_DEBOUNCE, 32'h2);
		wr(OFS_IRQ_MASK, 32'h1);
		chk({31'h0, HF_STARTED}, 32'h0);
		wr(OFS_TASK_HF_START, 32'h1);
		chk({31'h0, HF_XTAL_ENABLE}, 32'h1);
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while (HF_STARTED !== 1'b1 && n < 200);
		@(posedge CLK);
		chk(n, PU + 2 * DEBOUNCE_UNIT_CYC + 1);
		chk({31'h0, IRQ}, 32'h1);
		rd(OFS_IRQ_STATUS, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h1);
		chk({31'h0, IRQ}, 32'h0);
		wr(OFS_CAL_INTERVAL, 32'h0000_0055);
		wr(OFS_TRACE_CONFIG, 32'h0001_0003);
		rst_sys();
		rd(OFS_LF_SELECT, 32'h0);
		rd(OFS_HF_DEBOUNCE, 32'h10);
		rd(OFS_CAL_INTERVAL, 32'h0000_0055);
		rd(OFS_TRACE_CONFIG, 32'h0001_0003);
		DEBUG_RESET_N <= 1'b0;
		repeat (2) @(posedge CLK);
		DEBUG_RESET_N <= 1'b1;
		repeat (3) @(posedge CLK);
		rd(OFS_TRACE_CONFIG, 32'h0);
		rd(OFS_CAL_INTERVAL, 32'h0000_0055);
		POWER_ON_RESET_N <= 1'b0;
		repeat (2) @(posedge CLK);
		POWER_ON_RESET_N <= 1'b1;
		repeat (3) @(posedge CLK);
		rd(OFS_CAL_INTERVAL, 32'h0);
		for (int s = 0; s < 4; s++) begin
			x = (s < 3) ? s : 0;
			wr(OFS_TRACE_CONFIG, (x << 16) | s);
			rd(OFS_TRACE_CONFIG, (x << 16) | s);
			half(n);
			x = 125 * (1 << s) / 16;
			chk(n >= x - 1 && n <= x + 1, 32'h1);
			x = (s == 1) ? 1 : (s == 2) ? 6 : 0;
			chk({TRACE_CLOCK_ROUTED, TRACE_DATA_ROUTED, SERIAL_TRACE_ROUTED},
				x);
		end
		report_and_stop;
	end
endmodule
